// file: include/error_thermal_pkg.sv
// constants and types shared by the error and thermal signalling logic
package error_thermal_pkg;

    // -------------------------------------------------------------
    // fatal error timing
    // -------------------------------------------------------------
    // short fatal pulse length, counted in base clock cycles
    localparam int unsigned FATAL_PULSE_CYCLES = 16;

    // -------------------------------------------------------------
    // reset values and the open-drain low drive level
    // -------------------------------------------------------------
    localparam logic OD_RELEASED = 1'h0;
    localparam logic OD_LOW_LEVEL = 1'h0;
    localparam logic FLAG_CLEAR = 1'h0;
    localparam logic [1:0] RESET_SYNC_INIT = 2'h0;

    // -------------------------------------------------------------
    // fatal error timer states
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        FATAL_IDLE = 2'b00,
        FATAL_PULSE = 2'b01,
        FATAL_HOLD = 2'b10
    } fatal_state_t;

endpackage

// file: include/fatal_ctrl_if.sv
// request and status signals between the top and the fatal error timer
`timescale 1ns/1ps
interface fatal_ctrl_if;
    logic start;    // short-pulse error event
    logic hold;     // held error event
    logic clear;    // warm or cold reset entry
    logic active;   // fatal error output asserted

    modport ctrl (output start, output hold, output clear, input active);
    modport timer (input start, input hold, input clear, output active);
endinterface

// file: logic/fatal_error_timer.sv
// fatal error output timer: fixed-length pulse or hold until reset
`timescale 1ns/1ps
module fatal_error_timer #(
    parameter int unsigned PULSE_CYCLES = error_thermal_pkg::FATAL_PULSE_CYCLES
) (
    input wire logic i_clock,           // base clock
    input wire logic i_rst_n,           // synchronised reset, active low
    fatal_ctrl_if.timer bus             // control and status
);
    localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PULSE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    error_thermal_pkg::fatal_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic active_q;

    // -------------------------------------------------------------
    // next state: clear beats hold, hold beats start
    // -------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            error_thermal_pkg::FATAL_IDLE: begin
                if (bus.hold) begin
                    state_d = error_thermal_pkg::FATAL_HOLD;
                end else if (bus.start) begin
                    state_d = error_thermal_pkg::FATAL_PULSE;
                    cnt_d = CNT_LOAD;
                end
            end
            error_thermal_pkg::FATAL_PULSE: begin
                // counter steps on every base clock edge
                if (bus.hold) begin
                    state_d = error_thermal_pkg::FATAL_HOLD;
                end else if (cnt_q == CNT_ZERO) begin
                    state_d = error_thermal_pkg::FATAL_IDLE;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            error_thermal_pkg::FATAL_HOLD: begin
                state_d = error_thermal_pkg::FATAL_HOLD;
            end
            default: begin
                state_d = error_thermal_pkg::FATAL_IDLE;
            end
        endcase
        if (bus.clear) begin
            state_d = error_thermal_pkg::FATAL_IDLE;
            cnt_d = CNT_ZERO;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= error_thermal_pkg::FATAL_IDLE;
            cnt_q <= CNT_ZERO;
            active_q <= error_thermal_pkg::FLAG_CLEAR;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            active_q <= (state_d != error_thermal_pkg::FATAL_IDLE);
        end
    end

    assign bus.active = active_q;
endmodule

// file: logic/error_thermal_signalling.sv
// error and thermal protection pin logic of the device
`timescale 1ns/1ps
module error_thermal_signalling (
    input wire logic i_clock,                        // base clock, 50 MHz
    input wire logic i_arst_n,                       // asynchronous reset, active low
    input wire logic i_machine_check_error,          // one-cycle error event
    input wire logic i_internal_unrecoverable_error, // one-cycle error event
    input wire logic i_warm_reset,                   // warm reset entry
    input wire logic i_cold_reset,                   // cold reset entry
    input wire logic i_temp_at_max,                  // sensor at max safe temperature
    input wire logic i_thermal_control_enable,       // thermal control allowed on own heat
    input wire logic i_temp_over_trip,               // sensor above trip threshold
    input wire logic i_proc_overtemp_n,              // overtemp pin level
    output logic o_proc_overtemp_n,                  // overtemp pin drive value
    output logic o_proc_overtemp_n_oe,               // overtemp pin drive enable
    output logic o_fatal_error_n,                    // fatal error pin drive value
    output logic o_fatal_error_n_oe,                 // fatal error pin drive enable
    output logic o_thermal_trip_n,                   // thermal trip pin drive value
    output logic o_thermal_trip_n_oe,                // thermal trip pin drive enable
    output logic o_thermal_control_active,           // thermal control circuit engaged
    output logic o_execution_halt                    // all execution stopped
);
    // -------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync_q <= error_thermal_pkg::RESET_SYNC_INIT;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // -------------------------------------------------------------
    // fatal error signalling
    // -------------------------------------------------------------
    fatal_ctrl_if fatal_bus ();

    wire any_reset = i_warm_reset | i_cold_reset;

    assign fatal_bus.start = i_machine_check_error;
    assign fatal_bus.hold = i_internal_unrecoverable_error;
    assign fatal_bus.clear = any_reset;

    fatal_error_timer #(
        .PULSE_CYCLES(error_thermal_pkg::FATAL_PULSE_CYCLES)
    ) u_fatal_timer (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .bus(fatal_bus)
    );

    assign o_fatal_error_n = error_thermal_pkg::OD_LOW_LEVEL;
    assign o_fatal_error_n_oe = fatal_bus.active;

    // -------------------------------------------------------------
    // thermal signalling
    // -------------------------------------------------------------
    logic hot_drive_q;
    logic thermal_ctl_q;
    logic trip_q;

    // our own drive is masked so it does not read back as an outside request
    wire ext_hot = ~i_proc_overtemp_n & ~hot_drive_q;
    wire hot_drive_d = i_temp_at_max;
    wire thermal_ctl_d = (i_temp_at_max & i_thermal_control_enable) | ext_hot;
    // set wins over the cold reset clear
    wire trip_d = i_temp_over_trip | (trip_q & ~i_cold_reset);

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            hot_drive_q <= error_thermal_pkg::OD_RELEASED;
            thermal_ctl_q <= error_thermal_pkg::FLAG_CLEAR;
            trip_q <= error_thermal_pkg::FLAG_CLEAR;
        end else begin
            hot_drive_q <= hot_drive_d;
            thermal_ctl_q <= thermal_ctl_d;
            trip_q <= trip_d;
        end
    end

    assign o_proc_overtemp_n = error_thermal_pkg::OD_LOW_LEVEL;
    assign o_proc_overtemp_n_oe = hot_drive_q;
    assign o_thermal_trip_n = error_thermal_pkg::OD_LOW_LEVEL;
    assign o_thermal_trip_n_oe = trip_q;
    assign o_thermal_control_active = thermal_ctl_q;
    assign o_execution_halt = trip_q;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    logic held_err_seen_q;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            held_err_seen_q <= error_thermal_pkg::FLAG_CLEAR;
        end else if (any_reset) begin
            held_err_seen_q <= error_thermal_pkg::FLAG_CLEAR;
        end else if (i_internal_unrecoverable_error) begin
            held_err_seen_q <= 1'b1;
        end
    end

    // cycles the fatal pin has stood so far, saturating
    localparam logic [4:0] FATAL_LEN = 5'(error_thermal_pkg::FATAL_PULSE_CYCLES);
    logic [4:0] fatal_len_q;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            fatal_len_q <= 5'h0;
        end else if (!o_fatal_error_n_oe) begin
            fatal_len_q <= 5'h0;
        end else if (fatal_len_q != 5'h1f) begin
            fatal_len_q <= fatal_len_q + 5'h1;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_quiet;
        !i_internal_unrecoverable_error && !any_reset;
    endsequence

    sequence s_mce_start;
        i_machine_check_error && !i_internal_unrecoverable_error && !any_reset &&
            !o_fatal_error_n_oe;
    endsequence

    sequence s_mce_run16;
        s_mce_start ##1 s_quiet[*8] ##1 s_quiet[*8];
    endsequence

    property p_mce_high;
        s_mce_start ##1 s_quiet[*8] ##1 s_quiet[*7] |=> o_fatal_error_n_oe;
    endproperty
    a_mce_high: assert property (p_mce_high) else $error("short fatal pulse ended early");

    property p_mce_end;
        s_mce_run16 |=> !o_fatal_error_n_oe;
    endproperty
    a_mce_end: assert property (p_mce_end) else $error("short fatal pulse too long");

    property p_mce_first;
        s_mce_start |=> o_fatal_error_n_oe;
    endproperty
    a_mce_first: assert property (p_mce_first) else $error("fatal pulse not started");

    property p_internal_unrecoverable_error_hold;
        held_err_seen_q && !any_reset |=> o_fatal_error_n_oe;
    endproperty
    a_internal_unrecoverable_error_hold: assert property (p_internal_unrecoverable_error_hold) else $error("held fatal error dropped");

    property p_reset_release;
        any_reset |=> !o_fatal_error_n_oe;
    endproperty
    a_reset_release: assert property (p_reset_release) else $error("fatal kept over reset");

    property p_fatal_cause;
        $rose(o_fatal_error_n_oe) |->
            $past(i_machine_check_error) || $past(i_internal_unrecoverable_error);
    endproperty
    a_fatal_cause: assert property (p_fatal_cause) else $error("fatal error without cause");

    property p_hot_drive;
        ##1 (o_proc_overtemp_n_oe == $past(i_temp_at_max));
    endproperty
    a_hot_drive: assert property (p_hot_drive) else $error("overtemp drive mismatch");

    property p_ext_hot;
        !i_proc_overtemp_n && !o_proc_overtemp_n_oe |=> o_thermal_control_active;
    endproperty
    a_ext_hot: assert property (p_ext_hot) else $error("outside overtemp ignored");

    property p_trip_set;
        i_temp_over_trip |=> o_thermal_trip_n_oe && o_execution_halt;
    endproperty
    a_trip_set: assert property (p_trip_set) else $error("thermal trip not raised");

    property p_trip_stay;
        o_execution_halt && !i_cold_reset |=> o_execution_halt;
    endproperty
    a_trip_stay: assert property (p_trip_stay) else $error("halt released early");

    property p_trip_clear;
        o_execution_halt && i_cold_reset && !i_temp_over_trip |=> !o_execution_halt;
    endproperty
    a_trip_clear: assert property (p_trip_clear) else $error("halt kept over cold reset");

    property p_pulse_cap;
        o_fatal_error_n_oe && !held_err_seen_q |-> fatal_len_q < FATAL_LEN;
    endproperty
    a_pulse_cap: assert property (p_pulse_cap) else $error("short fatal pulse overlong");

    property p_pulse_full;
        $fell(o_fatal_error_n_oe) && !$past(any_reset) |-> fatal_len_q == FATAL_LEN;
    endproperty
    a_pulse_full: assert property (p_pulse_full) else $error("short fatal pulse length");

    property p_hold_turn;
        i_internal_unrecoverable_error && !any_reset ##1 !any_reset |=> o_fatal_error_n_oe;
    endproperty
    a_hold_turn: assert property (p_hold_turn) else $error("held fatal error not held");

    property p_ctrl_own;
        i_temp_at_max && i_thermal_control_enable |=> o_thermal_control_active;
    endproperty
    a_ctrl_own: assert property (p_ctrl_own) else $error("own heat did not engage control");

    property p_ctrl_cause;
        o_thermal_control_active |->
            $past(i_temp_at_max && i_thermal_control_enable) ||
            $past(!i_proc_overtemp_n && !o_proc_overtemp_n_oe);
    endproperty
    a_ctrl_cause: assert property (p_ctrl_cause) else $error("control engaged without cause");

endmodule

// file: tb/platform_ctrl_model.sv
// platform controller model: pull-ups on the open-drain pins and an outside overtemp driver
`timescale 1ns/1ps
module platform_ctrl_model (
    input wire logic i_clock,             // base clock
    input wire logic i_assert_req,        // pull the overtemp wire low
    input wire logic i_slow,              // answer two cycles late
    input wire logic i_overtemp_n,        // device overtemp drive value
    input wire logic i_overtemp_n_oe,     // device overtemp drive enable
    input wire logic i_fatal_error_n,     // device fatal drive value
    input wire logic i_fatal_error_n_oe,  // device fatal drive enable
    input wire logic i_thermal_trip_n,    // device trip drive value
    input wire logic i_thermal_trip_n_oe, // device trip drive enable
    output logic o_overtemp_wire,         // resolved overtemp level
    output logic o_fatal_wire,            // resolved fatal level
    output logic o_trip_wire              // resolved trip level
);
    logic [1:0] req_q = 2'h0;
    logic drive;
    always_ff @(posedge i_clock) begin
        req_q <= {req_q[0], i_assert_req};
    end
    // outside party engages the device's thermal control
    assign drive = i_slow ? req_q[1] : i_assert_req;
    // pull-ups win wherever nobody pulls low
    assign o_overtemp_wire = ~(drive | (i_overtemp_n_oe & ~i_overtemp_n));
    assign o_fatal_wire = ~(i_fatal_error_n_oe & ~i_fatal_error_n);
    assign o_trip_wire = ~(i_thermal_trip_n_oe & ~i_thermal_trip_n);
endmodule

// file: tb/tb_top.sv
// testbench for the error and thermal pin logic
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic mce = 1'b0, held_err = 1'b0, warm = 1'b0, cold = 1'b0;
    logic at_max = 1'b0, ctl_en = 1'b0, over_trip = 1'b0, ext_req = 1'b0, ext_slow = 1'b0;
    logic ovt_w, fat_w, trip_w, ovt_n, ovt_oe, fat_n, fat_oe, trip_n, trip_oe, ctrl, halt;
    logic [4:0] cur;
    logic [4:0] prev = 5'h0;
    logic [31:0] notes[$];
    int cyc = 0;
    int n_fail = 0;
    int compares = 0;
    bit live = 1'b0;

    error_thermal_signalling dut (.i_clock(clk), .i_arst_n(arst_n),
        .i_machine_check_error(mce), .i_internal_unrecoverable_error(held_err),
        .i_warm_reset(warm), .i_cold_reset(cold), .i_temp_at_max(at_max),
        .i_thermal_control_enable(ctl_en), .i_temp_over_trip(over_trip),
        .i_proc_overtemp_n(ovt_w),
        .o_proc_overtemp_n(ovt_n), .o_proc_overtemp_n_oe(ovt_oe), .o_fatal_error_n(fat_n),
        .o_fatal_error_n_oe(fat_oe), .o_thermal_trip_n(trip_n), .o_thermal_trip_n_oe(trip_oe),
        .o_thermal_control_active(ctrl), .o_execution_halt(halt));
    platform_ctrl_model pm (.i_clock(clk), .i_assert_req(ext_req), .i_slow(ext_slow),
        .i_overtemp_n(ovt_n), .i_overtemp_n_oe(ovt_oe), .i_fatal_error_n(fat_n),
        .i_fatal_error_n_oe(fat_oe), .i_thermal_trip_n(trip_n), .i_thermal_trip_n_oe(trip_oe),
        .o_overtemp_wire(ovt_w), .o_fatal_wire(fat_w), .o_trip_wire(trip_w));

    // own overtemp drive counts only when it really pulls the wire low
    assign cur = {~fat_w, ovt_oe & ~ovt_w, ctrl, ~trip_w, halt};

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic note(input int dc, input logic [4:0] v);
        notes.push_back({cyc[26:0] + 27'(dc), v});
    endtask
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (notes.size() != 0) n_fail++;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // -------------------------------------------------------------
    // clock, cycle count, timeout, monitor
    // -------------------------------------------------------------
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            results();
        end
    end
    always @(negedge clk) begin
        if (live && cur !== prev) begin
            if (notes.size() == 0) compare({cyc[26:0], cur}, 32'h0000_0000);
            else compare({cyc[26:0], cur}, notes.pop_front());
            prev = cur;
        end
    end

    // -------------------------------------------------------------
    // stimulus
    // -------------------------------------------------------------
    initial begin
        void'($urandom(30));
        tick(3);
        arst_n = 1'b1;
        tick(4);
        live = 1'b1;
        // short pulse, a second event inside it is ignored
        for (int i = 0; i < 3; i++) begin
            mce = 1'b1;
            note(1, 5'h10);
            note(17, 5'h00);
            tick(1);
            mce = 1'b0;
            tick($urandom_range(2, 14));
            mce = 1'b1;
            tick(1);
            mce = 1'b0;
            tick(20);
        end
        $display("test short pulse done");
        // held error during a pulse, released by warm then cold reset
        for (int r = 0; r < 2; r++) begin
            mce = 1'b1;
            note(1, 5'h10);
            tick(1);
            mce = 1'b0;
            tick(3);
            held_err = 1'b1;
            tick(1);
            held_err = 1'b0;
            tick($urandom_range(17, 40));
            if (r == 0) warm = 1'b1;
            else cold = 1'b1;
            note(1, 5'h00);
            tick(1);
            warm = 1'b0;
            cold = 1'b0;
            tick(3);
        end
        $display("test held error done");
        // own heat, with and without thermal control enabled
        for (int e = 0; e < 2; e++) begin
            ctl_en = e[0];
            at_max = 1'b1;
            note(1, {2'b01, e[0], 2'b00});
            tick(5);
            at_max = 1'b0;
            note(1, 5'h00);
            tick(3);
        end
        $display("test own heat done");
        // outside party pulls overtemp low, promptly then slowly
        for (int s = 0; s < 2; s++) begin
            ctl_en = 1'($urandom_range(0, 1));
            ext_slow = s[0];
            ext_req = 1'b1;
            note(1 + 2 * s, 5'h04);
            tick(6);
            ext_req = 1'b0;
            note(1 + 2 * s, 5'h00);
            tick(6);
        end
        $display("test outside overtemp done");
        // trip latches, survives warm reset, clears on cold reset
        over_trip = 1'b1;
        note(1, 5'h03);
        tick(4);
        over_trip = 1'b0;
        warm = 1'b1;
        tick(1);
        warm = 1'b0;
        tick(4);
        cold = 1'b1;
        note(1, 5'h00);
        tick(1);
        cold = 1'b0;
        tick(4);
        $display("test thermal trip done");
        results();
    end
endmodule
